//--- bench/dcr_regs_bench.sv
/*
  Self-checking bench for the identity and capability register bank.
  Assumes a single AHB-Lite master (this bench) with hready fed back
  from hreadyout, a 10 MHz hclk and active-low asynchronous hresetn.
*/
`timescale 1ns/1ns
`default_nettype none
module dcr_regs_bench
  import dcr_pkg::*;
();
  // fixed capability fields and free reserved positions
  localparam logic [31:0] CAP_EXP = 32'h0021_3445;
  localparam logic [31:0] FREE_BITS = 32'hFC08_8888;
  localparam int TIMEOUT_CYC = 5000;

  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, smp_rdata, rd;
  logic smp_ready, smp_resp;
  int num_errors, cmp_count, cyc;

  dcr_regs dcr_regs_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock, edge capture and hang guard
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // capture at the edge itself, so reading never races the design's flops
  always @(posedge hclk) begin
    smp_rdata <= hrdata;
    smp_ready <= hreadyout;
    smp_resp <= hresp;
    cyc <= cyc + 1;
    if (cyc == TIMEOUT_CYC) begin
      num_errors = num_errors + 1;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one single transfer: address phase, then data phase
  task automatic ahb_xfer(input logic wr, input logic [11:0] addr, input logic [2:0] size,
                          input logic [31:0] wdata, output logic [31:0] rdata);
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= DCR_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= size;
    @(posedge hclk);
    #1;
    while (smp_ready !== 1'b1) begin
      @(posedge hclk);
      #1;
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    @(posedge hclk);
    #1;
    while (smp_ready !== 1'b1) begin
      @(posedge hclk);
      #1;
    end
    rdata = smp_rdata;
    check("hresp", {31'h0, smp_resp}, {31'h0, DCR_HRESP_OKAY});
  endtask : ahb_xfer

  task automatic rd_word(input logic [11:0] addr, output logic [31:0] rdata);
    ahb_xfer(1'b0, addr, DCR_HSIZE_WORD, 32'h0, rdata);
  endtask : rd_word

  task automatic wr_word(input logic [11:0] addr, input logic [31:0] wdata);
    logic [31:0] dummy;
    ahb_xfer(1'b1, addr, DCR_HSIZE_WORD, wdata, dummy);
  endtask : wr_word

  // every fixed field of the capability word, fill bits as given
  task automatic check_caps(input logic [31:0] fill_bits);
    logic [31:0] c;
    rd_word(DCR_OFS_CAPS, c);
    check("cap_prot", 32'(c[25]), 32'h0);
    check("cap_chmap", 32'(c[24]), 32'h0);
    check("cap_regn", 32'(c[21:20]), 32'h2);
    check("cap_evq", 32'(c[18:16]), 32'h1);
    check("cap_pset", 32'(c[14:12]), 32'h3);
    check("cap_intch", 32'(c[10:8]), 32'h4);
    check("cap_qch", 32'(c[6:4]), 32'h4);
    check("cap_dmach", 32'(c[2:0]), 32'h5);
    check("cap_word", c, CAP_EXP | fill_bits);
  endtask : check_caps

  task automatic test_done(input string name);
    $display("test %s done", name);
  endtask : test_done

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    num_errors = 0;
    cmp_count = 0;
    cyc = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = DCR_HSIZE_WORD;
    hwdata = 32'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    // identity and capabilities after reset
    rd_word(DCR_OFS_IDENTITY, rd);
    check("identity", rd, DCR_IDENTITY_CODE);
    check_caps(32'h0);
    test_done("reset_values");
    // writes to read-only registers change nothing and are not counted
    wr_word(DCR_OFS_IDENTITY, 32'hFFFF_FFFF);
    wr_word(DCR_OFS_CAPS, 32'hFFFF_FFFF);
    rd_word(DCR_OFS_IDENTITY, rd);
    check("identity_after_wr", rd, DCR_IDENTITY_CODE);
    check_caps(32'h0);
    rd_word(DCR_OFS_STAT, rd);
    check("stat_after_ro_wr", rd, 32'h0);
    rd_word(DCR_OFS_CTRL, rd);
    check("ctrl_after_ro_wr", rd, 32'h0);
    test_done("read_only_writes");
    // free reserved bits follow the fill level, 23-22 stay zero
    wr_word(DCR_OFS_CTRL, 32'h1);
    check_caps(FREE_BITS);
    test_done("reserved_fill");
    // unmapped and non-word accesses read zero with OKAY
    rd_word(12'h010, rd);
    check("unmapped_rd", rd, 32'h0);
    ahb_xfer(1'b0, DCR_OFS_IDENTITY, 3'h0, 32'h0, rd);
    check("byte_rd", rd, 32'h0);
    rd_word(DCR_OFS_STAT, rd);
    check("stat_misses", rd, 32'h2);
    wr_word(DCR_OFS_STAT, 32'h0);
    rd_word(DCR_OFS_STAT, rd);
    check("stat_cleared", rd, 32'h0);
    test_done("unmapped");
    // reset in mid-run returns the fill level to zero
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    check_caps(32'h0);
    rd_word(DCR_OFS_IDENTITY, rd);
    check("identity_rerst", rd, DCR_IDENTITY_CODE);
    test_done("mid_reset");
    end_sim();
  end

endmodule : dcr_regs_bench
`default_nettype wire

//--- rtl/dcr_ahb_decode.sv
/*
  Address-phase decode of the AHB-Lite register port.
  Assumes haddr, htrans, hsize and hwrite are valid while hready is high.
*/
`timescale 1ns/1ns
`default_nettype none
module dcr_ahb_decode
  import dcr_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic hsel,
  input wire logic hready,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [ADDR_W-1:0] haddr,
  output logic acc_rd,
  output logic acc_wr,
  output logic acc_hit,
  output logic [1:0] acc_idx
);

  logic acc_valid;

  // seq and nonseq both start a transfer; only whole aligned words hit
  assign acc_valid = hsel & hready & htrans[1];
  assign acc_rd = acc_valid & ~hwrite;
  assign acc_wr = acc_valid & hwrite;
  assign acc_idx = haddr[3:2];
  assign acc_hit = (haddr[ADDR_W-1:4] == '0) & (haddr[1:0] == 2'h0)
                   & (hsize == DCR_HSIZE_WORD);

endmodule : dcr_ahb_decode
`default_nettype wire

//--- rtl/dcr_cap_compose.sv
/*
  Builds the capability word from the fixed resource codes.
  Assumes the fill level is steady for the cycle in which it is sampled.
*/
`timescale 1ns/1ns
`default_nettype none
module dcr_cap_compose
  import dcr_pkg::*;
(
  input wire logic fill,
  output logic [31:0] cap_word
);

  logic [31:0] base;

  // fixed codes; reserved positions start at zero
  always_comb begin
    base = 32'h0000_0000;
    base[DCR_CAP_PROT_BIT] = DCR_CAP_PROT;
    base[DCR_CAP_CHMAP_BIT] = DCR_CAP_CHMAP;
    base[DCR_CAP_REGN_LSB +: 2] = DCR_CAP_REGN;
    base[DCR_CAP_EVQ_LSB +: 3] = DCR_CAP_EVQ;
    base[DCR_CAP_PSET_LSB +: 3] = DCR_CAP_PSET;
    base[DCR_CAP_INTCH_LSB +: 3] = DCR_CAP_INTCH;
    base[DCR_CAP_QCH_LSB +: 3] = DCR_CAP_QCH;
    base[DCR_CAP_DMACH_LSB +: 3] = DCR_CAP_DMACH;
  end

  // free reserved bits follow the fill level, forced ones stay zero
  for (genvar b = 0; b < 32; b++) begin : g_bit
    if (DCR_CAP_FREE_MASK[b]) begin : g_free
      assign cap_word[b] = fill;
    end else begin : g_fixed
      assign cap_word[b] = base[b] & ~DCR_CAP_ZERO_MASK[b];
    end
  end

endmodule : dcr_cap_compose
`default_nettype wire

//--- rtl/dcr_pkg.sv
/*
  Constants of the DMA controller identity and capability register bank:
  register offsets, capability field positions and codes, reserved masks.
  Assumes a 32-bit AHB-Lite register port with word-aligned registers.
*/
package dcr_pkg;

  // register byte offsets within the bank
  localparam logic [11:0] DCR_OFS_IDENTITY = 12'h000;
  localparam logic [11:0] DCR_OFS_CAPS = 12'h004;
  localparam logic [11:0] DCR_OFS_CTRL = 12'h008;
  localparam logic [11:0] DCR_OFS_STAT = 12'h00C;

  // identity code: value is arbitrary, not taken from any product
  localparam logic [31:0] DCR_IDENTITY_CODE = 32'h5A5A_0001;

  // capability field positions
  localparam int DCR_CAP_PROT_BIT = 25;
  localparam int DCR_CAP_CHMAP_BIT = 24;
  localparam int DCR_CAP_REGN_LSB = 20;
  localparam int DCR_CAP_EVQ_LSB = 16;
  localparam int DCR_CAP_PSET_LSB = 12;
  localparam int DCR_CAP_INTCH_LSB = 8;
  localparam int DCR_CAP_QCH_LSB = 4;
  localparam int DCR_CAP_DMACH_LSB = 0;

  // capability field codes
  localparam logic DCR_CAP_PROT = 1'h0;
  localparam logic DCR_CAP_CHMAP = 1'h0;
  localparam logic [1:0] DCR_CAP_REGN = 2'h2;
  localparam logic [2:0] DCR_CAP_EVQ = 3'h1;
  localparam logic [2:0] DCR_CAP_PSET = 3'h3;
  localparam logic [2:0] DCR_CAP_INTCH = 3'h4;
  localparam logic [2:0] DCR_CAP_QCH = 3'h4;
  localparam logic [2:0] DCR_CAP_DMACH = 3'h5;

  // reserved bits: forced zero, and free (fill) bits
  localparam logic [31:0] DCR_CAP_ZERO_MASK = 32'h00C0_0000;
  localparam logic [31:0] DCR_CAP_FREE_MASK = 32'hFC08_8888;

  // control register layout and reset
  localparam int DCR_CTRL_FILL_BIT = 0;
  localparam logic DCR_CTRL_FILL_RESET = 1'h0;

  // bus encodings
  localparam logic [1:0] DCR_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] DCR_HSIZE_WORD = 3'h2;
  localparam logic DCR_HRESP_OKAY = 1'h0;

endpackage : dcr_pkg

//--- rtl/dcr_regs.sv
/*
  Identity and capability register bank of a DMA channel controller,
  reached as a zero-wait AHB-Lite slave, plus a small control and
  status pair for the reserved-bit fill level and unmapped accesses.
  Assumes a single master, one clock hclk and reset hresetn.
*/
//
// Overview of operation
// - identity register returns one fixed 32-bit code
// - capability bit 25 reads zero, no protection
// - capability bit 24 reads zero, fixed mapping
// - bits 21-20 read 2h, four shadow regions
// - bits 18-16 read 1, two event queues
// - bits 14-12 read 3h, 128 parameter sets
// - bits 10-8 read 4h, 64 interrupt channels
// - bits 6-4 read 4h, 8 quick channels
// - bits 2-0 read 5h, 64 DMA channels
// - bits 23-22 zero, other reserved free
`timescale 1ns/1ns
`default_nettype none
module dcr_regs
  import dcr_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int CNT_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  //////////////////////////////////////////////////////////////////////
  // address phase decode

  logic acc_rd;
  logic acc_wr;
  logic acc_hit;
  logic [1:0] acc_idx;

  dcr_ahb_decode #(
    .ADDR_W(ADDR_W)
  ) u_decode (
    .hsel(hsel),
    .hready(hready),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .haddr(haddr),
    .acc_rd(acc_rd),
    .acc_wr(acc_wr),
    .acc_hit(acc_hit),
    .acc_idx(acc_idx)
  );

  //////////////////////////////////////////////////////////////////////
  // state declarations

  logic wr_pend_ff;
  logic nxt_wr_pend;
  logic [1:0] wr_idx_ff;
  logic [1:0] nxt_wr_idx;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;
  logic hreadyout_ff;
  logic nxt_hreadyout;
  logic hresp_ff;
  logic nxt_hresp;
  logic fill_ff;
  logic nxt_fill;
  logic [CNT_W-1:0] miss_cnt_ff;
  logic [CNT_W-1:0] nxt_miss_cnt;

  logic ctrl_wr_now;
  logic stat_wr_now;
  logic fill_eff;
  logic [31:0] cap_word;
  logic [31:0] rd_word;
  logic miss_now;

  //////////////////////////////////////////////////////////////////////
  // capability word

  // a read right behind a control write must see the new fill level
  assign ctrl_wr_now = wr_pend_ff & (wr_idx_ff == DCR_OFS_CTRL[3:2]);
  assign stat_wr_now = wr_pend_ff & (wr_idx_ff == DCR_OFS_STAT[3:2]);
  assign fill_eff = ctrl_wr_now ? hwdata[DCR_CTRL_FILL_BIT] : fill_ff;

  dcr_cap_compose u_compose (
    .fill(fill_eff),
    .cap_word(cap_word)
  );

  //////////////////////////////////////////////////////////////////////
  // read multiplexer

  // unmapped or odd-sized reads return zero rather than an error
  always_comb begin
    rd_word = 32'h0000_0000;
    if (acc_hit) begin
      unique case (acc_idx)
        DCR_OFS_IDENTITY[3:2]: rd_word = DCR_IDENTITY_CODE;
        DCR_OFS_CAPS[3:2]: rd_word = cap_word;
        DCR_OFS_CTRL[3:2]: begin
          rd_word[DCR_CTRL_FILL_BIT] = fill_eff;
        end
        DCR_OFS_STAT[3:2]: begin
          rd_word[CNT_W-1:0] = stat_wr_now ? '0 : miss_cnt_ff;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // bus pipeline: zero wait, data registered at the address phase

  // the read word is picked at the address phase so hrdata leaves a flop,
  // at the cost of a decode path from haddr straight into that flop
  always_comb begin
    nxt_wr_pend = acc_wr & acc_hit;
    nxt_wr_idx = acc_wr ? acc_idx : wr_idx_ff;
    nxt_hrdata = acc_rd ? rd_word : 32'h0000_0000;
    nxt_hreadyout = 1'b1; // never stretched
    nxt_hresp = DCR_HRESP_OKAY;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 2'h0;
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      wr_idx_ff <= nxt_wr_idx;
      hrdata_ff <= nxt_hrdata;
      hreadyout_ff <= nxt_hreadyout;
      hresp_ff <= nxt_hresp;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;

  //////////////////////////////////////////////////////////////////////
  // control register: only the fill level is writable

  // identity and capability writes fall through here untouched
  always_comb begin
    nxt_fill = fill_ff;
    if (ctrl_wr_now) begin
      nxt_fill = hwdata[DCR_CTRL_FILL_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fill_ff <= DCR_CTRL_FILL_RESET;
    end else begin
      fill_ff <= nxt_fill;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // unmapped access counter, saturating, cleared by a status write

  assign miss_now = (acc_rd | acc_wr) & ~acc_hit;

  // a miss in the clearing cycle survives as a count of one
  always_comb begin
    nxt_miss_cnt = miss_cnt_ff;
    if (stat_wr_now) begin
      nxt_miss_cnt = miss_now ? CNT_W'(1) : '0;
    end else if (miss_now && (miss_cnt_ff != '1)) begin
      nxt_miss_cnt = miss_cnt_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      miss_cnt_ff <= '0;
    end else begin
      miss_cnt_ff <= nxt_miss_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks on the read values and the write behaviour

  logic rd_id;
  logic rd_cap;
  logic wr_ro;

  assign rd_id = acc_rd & acc_hit & (acc_idx == DCR_OFS_IDENTITY[3:2]);
  assign rd_cap = acc_rd & acc_hit & (acc_idx == DCR_OFS_CAPS[3:2]);
  assign wr_ro = acc_wr & acc_hit & ~acc_idx[1];

  AST_IDENTITY_CODE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_id |=> (hrdata == DCR_IDENTITY_CODE) && hreadyout)
    else $error("identity read returned a wrong code");

  AST_CAP_NO_PROT: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> !hrdata[25])
    else $error("capability protection bit not zero");

  AST_CAP_NO_CHMAP: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> !hrdata[24])
    else $error("capability channel mapping bit not zero");

  AST_CAP_REGIONS: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> (hrdata[21:20] == 2'h2))
    else $error("shadow region code wrong");

  AST_CAP_QUEUES: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> (hrdata[18:16] == 3'h1))
    else $error("event queue code wrong");

  AST_CAP_PSETS: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> (hrdata[14:12] == 3'h3))
    else $error("parameter set code wrong");

  AST_CAP_INTCH: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> (hrdata[10:8] == 3'h4))
    else $error("interrupt channel code wrong");

  AST_CAP_QCH: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> (hrdata[6:4] == 3'h4))
    else $error("quick channel code wrong");

  AST_CAP_DMACH: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> (hrdata[2:0] == 3'h5))
    else $error("DMA channel code wrong");

  AST_CAP_RESERVED: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> (hrdata[23:22] == 2'h0)
      && (hrdata[31:26] == {6{$past(fill_eff)}}))
    else $error("reserved capability bits wrong");

  AST_RO_WRITE_IGNORED: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ro |=> !hresp && hreadyout ##1 $stable(fill_ff)
      && ($stable(miss_cnt_ff) || $past(miss_now)))
    else $error("write to read-only register changed state");

  //////////////////////////////////////////////////////////////////////
  // checks on the bus answer and the reserved fill

  // the port never stretches a transfer
  AST_BUS_READY: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hreadyout)
    else $error("bus ready dropped");

  // every transfer, mapped or not, is answered without an error
  AST_BUS_OKAY: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hresp == DCR_HRESP_OKAY)
    else $error("bus answered with an error");

  // outside a read data phase the read bus rests at zero
  AST_RD_IDLE_ZERO: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !acc_rd |=> (hrdata == 32'h0000_0000))
    else $error("read data present outside a read");

  // the low free reserved bits track the fill level like bits 31-26
  AST_CAP_FREE_LOW: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> (hrdata[19] == $past(fill_eff)) && (hrdata[15] == $past(fill_eff))
      && (hrdata[11] == $past(fill_eff)) && (hrdata[7] == $past(fill_eff))
      && (hrdata[3] == $past(fill_eff)))
    else $error("low reserved capability bits wrong");

  // fixed fields as one word, free positions masked out; the constant
  // is spelled out so a slip in the field table cannot hide itself
  AST_CAP_WORD: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |=> ((hrdata & ~DCR_CAP_FREE_MASK) == 32'h0021_3445))
    else $error("capability word wrong");

  // the fill level moves only with a control write
  AST_FILL_HOLDS: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !ctrl_wr_now |=> $stable(fill_ff))
    else $error("fill level changed without a control write");

  // a write to a read-only register is a hit, so it must not count
  // as an unmapped access; a status clear in that cycle is left out
  AST_RO_WRITE_NO_MISS: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ro && !stat_wr_now |=> $stable(miss_cnt_ff))
    else $error("read-only write counted as unmapped");

  //////////////////////////////////////////////////////////////////////
  // checks on the unmapped access counter

  // each miss adds one until the counter is full; software reads
  // the count to find stray accesses, so a lost step hides one
  AST_MISS_COUNT_UP: assert property (
    @(posedge hclk) disable iff (!hresetn)
    miss_now && !stat_wr_now && (miss_cnt_ff != '1)
      |=> (miss_cnt_ff == $past(miss_cnt_ff) + CNT_W'(1)))
    else $error("miss counter did not step");

  // the counter stops at its top value instead of wrapping
  AST_MISS_SATURATE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    miss_now && !stat_wr_now && (miss_cnt_ff == '1) |=> (miss_cnt_ff == '1))
    else $error("miss counter wrapped");

  // a miss in the clearing cycle leaves a count of one
  AST_MISS_CLEAR_SET: assert property (
    @(posedge hclk) disable iff (!hresetn)
    stat_wr_now && miss_now |=> (miss_cnt_ff == CNT_W'(1)))
    else $error("miss lost in the clearing cycle");

  // a clear with no miss empties the counter
  AST_MISS_CLEAR: assert property (
    @(posedge hclk) disable iff (!hresetn)
    stat_wr_now && !miss_now |=> (miss_cnt_ff == '0))
    else $error("miss counter not cleared");

endmodule : dcr_regs
`default_nettype wire
